// File: common/sspo_pkg.sv
// package of constants for the software stack pointer instruction executor
package sspo_pkg;
    // ==========================================
    // widths
    localparam int PTR_W = 12;
    localparam int PC_W = 21;
    localparam int OPC_W = 16;
    localparam int LIT6_W = 6;
    localparam int LIT8_W = 8;
    localparam int SEL_W = 2;
    localparam int NUM_PTR = 3;
    // ==========================================
    // opcode upper bytes and pointer selector codes
    localparam logic [7:0] OPC_PUSH_HI = 8'hEA;
    localparam logic [7:0] OPC_SUBP_HI = 8'hE9;
    localparam logic [1:0] SEL_RETURN = 2'h3;
    localparam logic [1:0] SEL_FRAME = 2'h2;
    // ==========================================
    // reset values
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [1:0] PHASE_RST = 2'h0;
    // ==========================================
    // phase numbers within an instruction cycle
    localparam logic [1:0] PH_DECODE = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_PROC = 2'h2;
    localparam logic [1:0] PH_WRITE = 2'h3;
    typedef enum logic [1:0] {SSPO_EXEC, SSPO_NOP} sspo_state_t;
endpackage : sspo_pkg

// File: verilog/sspo_decode.sv
// opcode decoder for the three stack instructions
`timescale 1ns/1ps
`default_nettype none
module sspo_decode
    import sspo_pkg::*;
(
    // instruction word and mode
    input wire logic [15:0] opcode,
    input wire logic ext_enable,
    // decoded classes
    output logic is_push,
    output logic is_subp,
    output logic is_subret,
    // operand fields
    output logic [1:0] sel,
    output logic [5:0] lit6,
    output logic [7:0] lit8
);
    // field extraction
    assign sel = opcode[7:6];
    assign lit6 = opcode[5:0];
    assign lit8 = opcode[7:0];
    // class decode, only with the extended set enabled
    wire logic subp_family = ext_enable && (opcode[15:8] == OPC_SUBP_HI);
    assign is_push = ext_enable && (opcode[15:8] == OPC_PUSH_HI);
    assign is_subp = subp_family && (sel != SEL_RETURN);
    assign is_subret = subp_family && (sel == SEL_RETURN);
endmodule : sspo_decode
`default_nettype wire

// File: verilog/sspo_exec.sv
// executes push-literal, pointer-subtract and subtract-and-return
`timescale 1ns/1ps
`default_nettype none
module sspo_exec
    import sspo_pkg::*;
#(
    parameter int PTR_WIDTH = PTR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // instruction stream
    input wire logic [15:0] opcode,
    input wire logic opcode_valid,
    input wire logic extended_set_config_bit,
    // return stack
    input wire logic [20:0] return_stack_top,
    output logic return_stack_pop,
    // program counter load
    output logic [20:0] pc_load_value,
    output logic pc_load,
    // data memory write port
    output logic [PTR_WIDTH-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    // status
    output logic status_write_en,
    output logic [1:0] phase,
    output logic busy,
    output logic [PTR_WIDTH-1:0] file_select_pointer_0,
    output logic [PTR_WIDTH-1:0] file_select_pointer_1,
    output logic [PTR_WIDTH-1:0] frame_pointer
);
    // ==========================================
    // parameter check
    // pointers narrower than the byte literal or wider than sixteen bits are refused
    if (PTR_WIDTH < LIT8_W || PTR_WIDTH > 16) begin : g_bad_width
        $error("pointer width must be between 8 and 16");
    end

    // ==========================================
    // decode
    // the decoder is pure logic; its outputs are read only in the decode phase
    logic is_push;
    logic is_subp;
    logic is_subret;
    logic [1:0] sel;
    logic [5:0] lit6;
    logic [7:0] lit8;
    sspo_decode u_dec (
        .opcode(opcode),
        .ext_enable(extended_set_config_bit),
        .is_push(is_push),
        .is_subp(is_subp),
        .is_subret(is_subret),
        .sel(sel),
        .lit6(lit6),
        .lit8(lit8)
    );

    // ==========================================
    // phase counter and latched instruction
    logic [1:0] phase_ff;
    sspo_state_t state_ff;
    sspo_state_t nxt_state;
    logic push_ff;
    logic subp_ff;
    logic subret_ff;
    logic [1:0] sel_ff;
    logic [5:0] lit6_ff;
    logic [7:0] lit8_ff;
    logic [PTR_WIDTH-1:0] ptr_ff [NUM_PTR];
    logic [PTR_WIDTH-1:0] operand_ff;
    logic [PTR_WIDTH-1:0] result_ff;

    // one-hot view of the four phases
    wire logic at_decode = (phase_ff == PH_DECODE);
    wire logic at_read = (phase_ff == PH_READ);
    wire logic at_proc = (phase_ff == PH_PROC);
    wire logic at_write = (phase_ff == PH_WRITE);
    wire logic take = at_decode && opcode_valid && (state_ff == SSPO_EXEC);
    // subtract-and-return always targets the frame pointer
    wire logic [1:0] dst_sel = subret_ff ? SEL_FRAME : sel_ff;
    wire logic [PTR_WIDTH-1:0] lit_dec = subp_ff || subret_ff
        ? PTR_WIDTH'(lit6_ff) : PTR_WIDTH'(1);
    wire logic [PTR_WIDTH-1:0] diff = operand_ff - lit_dec;
    wire logic ptr_write = at_write && (push_ff || subp_ff || subret_ff);
    // source pointer: push always reads the frame pointer
    wire logic [1:0] src_sel = push_ff ? SEL_FRAME : dst_sel;
    // index 3 has no pointer behind it, so it falls back to the frame pointer
    wire logic [PTR_WIDTH-1:0] src_ptr = (src_sel == SEL_RETURN) ? ptr_ff[SEL_FRAME]
        : ptr_ff[src_sel];
    // strobes for the write port and the return, raised in the process phase
    wire logic push_store = at_proc && push_ff;
    wire logic ret_jump = at_proc && subret_ff;

    // state sequencing: second cycle of the return is a no-operation
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SSPO_EXEC: begin
                if (at_write && subret_ff) begin
                    nxt_state = SSPO_NOP;
                end
            end
            SSPO_NOP: begin
                if (at_write) begin
                    nxt_state = SSPO_EXEC;
                end
            end
            default: nxt_state = SSPO_EXEC;
        endcase
    end

    // phase counter, always running
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_ff <= PHASE_RST;
            state_ff <= SSPO_EXEC;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            state_ff <= nxt_state;
        end
    end

    // instruction latch at decode phase, cleared at the end of the cycle
    // the latch drops to idle at the write phase so a stale command is never replayed
    always_ff @(posedge clk) begin
        if (!reset_n || (at_write && !take)) begin
            push_ff <= 1'b0;
            subp_ff <= 1'b0;
            subret_ff <= 1'b0;
            sel_ff <= 2'h0;
            lit6_ff <= 6'h00;
            lit8_ff <= 8'h00;
        end else if (take) begin
            push_ff <= is_push;
            subp_ff <= is_subp;
            subret_ff <= is_subret;
            sel_ff <= sel;
            lit6_ff <= lit6;
            lit8_ff <= lit8;
        end
    end

    // read and process phases; the difference is registered so the write
    // phase stores a settled value and the bank never sees a half-built result
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            operand_ff <= PTR_WIDTH'(PTR_RST);
            result_ff <= PTR_WIDTH'(PTR_RST);
        end else begin
            if (at_read) begin
                operand_ff <= src_ptr;
            end
            if (at_proc) begin
                result_ff <= diff;
            end
        end
    end

    // pointer bank, one write port at the write phase
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
            wire logic hit = (src_sel == SEL_W'(gi));
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    ptr_ff[gi] <= PTR_WIDTH'(PTR_RST);
                end else if (ptr_write && hit) begin
                    ptr_ff[gi] <= result_ff;
                end
            end
        end
    endgenerate

    // data memory write port, raised in the write phase of a push
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_we <= 1'b0;
            mem_addr <= PTR_WIDTH'(PTR_RST);
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= push_store;
            mem_addr <= operand_ff;
            mem_wdata <= lit8_ff;
        end
    end

    // pc load and stack pop; the stack top is sampled every clock so the
    // value shown with the load is the one that stood in the process phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc_load <= 1'b0;
            return_stack_pop <= 1'b0;
            pc_load_value <= PC_RST;
        end else begin
            pc_load <= ret_jump;
            return_stack_pop <= ret_jump;
            pc_load_value <= return_stack_top;
        end
    end

    // flags are never touched by these instructions
    assign status_write_en = 1'b0;
    assign phase = phase_ff;
    assign busy = (state_ff == SSPO_NOP);
    // pointer values shown straight from the bank flops
    assign file_select_pointer_0 = ptr_ff[0];
    assign file_select_pointer_1 = ptr_ff[1];
    assign frame_pointer = ptr_ff[SEL_FRAME];
endmodule : sspo_exec
`default_nettype wire

// File: bench/sspo_exec_properties.sv
// concurrent checks on the executor ports
`timescale 1ns/1ps
`default_nettype none
module sspo_exec_properties #(
    parameter int PTR_WIDTH = 12
) (
    // inputs to the executor
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] opcode,
    input wire logic extended_set_config_bit,
    input wire logic [20:0] return_stack_top,
    // executor outputs
    input wire logic [20:0] pc_load_value,
    input wire logic pc_load,
    input wire logic [PTR_WIDTH-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic [1:0] phase,
    input wire logic busy,
    input wire logic [PTR_WIDTH-1:0] frame_pointer
);
    // ==========
    // helpers
    wire logic [7:0] push_lit = opcode[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // return: four stalled clocks, then free again
    sequence s_stall; busy [*4]; endsequence
    sequence s_free; !busy; endsequence
    chk_push_addr: assert property (mem_we |-> mem_addr == frame_pointer)
        else $error("push address wrong");
    chk_push_literal: assert property (mem_we |-> mem_wdata == $past(push_lit, 3))
        else $error("push data wrong");
    chk_fp_decrement: assert property (mem_we |=> frame_pointer == $past(frame_pointer) - 1'b1)
        else $error("frame pointer not decremented");
    chk_pc_from_top: assert property (pc_load |-> pc_load_value == $past(return_stack_top))
        else $error("pc load value wrong");
    chk_load_phase: assert property (pc_load |-> phase == 2'h3)
        else $error("pc load out of phase");
    chk_nop_after: assert property (pc_load |=> s_stall ##1 s_free)
        else $error("return stall length wrong");
    chk_ext_gate: assert property (phase == 2'h0 && !extended_set_config_bit |-> ##3 !mem_we && !pc_load)
        else $error("opcode ran with extended set off");
    chk_phase_step: assert property ($past(reset_n) |-> phase == $past(phase) + 2'h1)
        else $error("phase did not advance");
endmodule : sspo_exec_properties
`default_nettype wire

// File: bench/sspo_mem_model.sv
// data memory and return stack facing the executor
`timescale 1ns/1ps
`default_nettype none
module sspo_mem_model (
    // clock
    input wire logic clk,
    // data memory write port
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    // return stack
    input wire logic return_stack_pop,
    output logic [20:0] return_stack_top
);
    logic [7:0] mem_ff [4096];
    logic [20:0] top_ff = 21'h0ABCDE;
    // byte store on write strobe, new stack top after each pop
    always @(posedge clk) begin
        if (mem_we) mem_ff[mem_addr] <= mem_wdata;
        if (return_stack_pop) top_ff <= top_ff * 21'h000005 + 21'h000003;
    end
    assign return_stack_top = top_ff;
endmodule : sspo_mem_model
`default_nettype wire

// File: bench/software_stack_pointer_ops_tb_top.sv
// self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module software_stack_pointer_ops_tb_top
    import sspo_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic opcode_valid = 1'b0;
    logic extended_set_config_bit = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic [20:0] return_stack_top, pc_load_value;
    logic return_stack_pop, pc_load, mem_we, status_write_en, busy;
    logic [11:0] mem_addr, p0, p1, fp;
    logic [11:0] m_ptr [3];
    logic [7:0] mem_wdata;
    logic [1:0] phase;
    logic [15:0] k;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    sspo_exec sspo_exec_i (.clk(clk), .reset_n(reset_n), .opcode(opcode),
        .opcode_valid(opcode_valid), .extended_set_config_bit(extended_set_config_bit),
        .return_stack_top(return_stack_top), .return_stack_pop(return_stack_pop),
        .pc_load_value(pc_load_value), .pc_load(pc_load), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .status_write_en(status_write_en),
        .phase(phase), .busy(busy), .file_select_pointer_0(p0),
        .file_select_pointer_1(p1), .frame_pointer(fp));
    sspo_mem_model sspo_mem_model_i (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .return_stack_pop(return_stack_pop),
        .return_stack_top(return_stack_top));
    // clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    task complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        checked++;
        if (e !== g) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one instruction: wait for a free decode phase, issue, follow it to its end
    task automatic run(input logic [15:0] op, input logic xb);
        logic push, subp, ret;
        logic [1:0] s;
        logic [11:0] old_fp;
        logic [20:0] top_seen;
        int n;
        n = 0;
        while (!(phase === PH_DECODE && busy === 1'b0) && n < 20) begin
            @(posedge clk) #2;
            n++;
        end
        chk("issue_slot", 1'b1, n < 20);
        push = xb && op[15:8] == OPC_PUSH_HI;
        subp = xb && op[15:8] == OPC_SUBP_HI;
        s = op[7:6];
        ret = subp && s == SEL_RETURN;
        old_fp = m_ptr[2];
        top_seen = return_stack_top;
        opcode = op;
        opcode_valid = 1'b1;
        extended_set_config_bit = xb;
        @(posedge clk) #2;
        opcode_valid = 1'b0;
        extended_set_config_bit = 1'($urandom);
        repeat (2) @(posedge clk) #2;
        chk("mem_we", push, mem_we);
        chk("pop", ret, return_stack_pop);
        if (ret) chk("pc_load_value", top_seen, pc_load_value);
        chk("pc_load", ret, pc_load);
        if (push) chk("mem_addr", old_fp, mem_addr);
        if (push) chk("mem_wdata", op[7:0], mem_wdata);
        chk("status_write_en", 1'b0, status_write_en);
        @(posedge clk) #2;
        if (push) m_ptr[2] = m_ptr[2] - 12'h001;
        if (subp) m_ptr[ret ? 2 : s] = m_ptr[ret ? 2 : s] - op[5:0];
        if (push) chk("mem", op[7:0], sspo_mem_model_i.mem_ff[old_fp]);
        chk("fsp0", m_ptr[0], p0);
        chk("fsp1", m_ptr[1], p1);
        chk("fp", m_ptr[2], fp);
        chk("busy", ret, busy);
    endtask : run
    // reset, directed walks, random mix, reset in mid-run
    initial begin
        void'($urandom(32'hA5C8EED5));
        m_ptr = '{12'h000, 12'h000, 12'h000};
        repeat (2) @(posedge clk);
        #2 reset_n = 1'b1;
        run(16'hEA08, 1'b1);
        run(16'hE9E3, 1'b1);
        for (int i = 0; i < 80; i++) begin
            k = 16'($urandom);
            run({(i % 4 == 0) ? OPC_PUSH_HI : (i % 4 == 3) ? k[15:8] : OPC_SUBP_HI, k[7:0]},
                i % 7 != 6);
        end
        reset_n = 1'b0;
        @(posedge clk) #2;
        reset_n = 1'b1;
        m_ptr = '{12'h000, 12'h000, 12'h000};
        run(16'hEA55, 1'b1);
        complete_run();
    end
endmodule : software_stack_pointer_ops_tb_top
bind sspo_exec sspo_exec_properties #(.PTR_WIDTH(PTR_WIDTH)) sspo_exec_properties_i (
    .clk(clk), .reset_n(reset_n), .opcode(opcode),
    .extended_set_config_bit(extended_set_config_bit), .return_stack_top(return_stack_top),
    .pc_load_value(pc_load_value), .pc_load(pc_load), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .phase(phase), .busy(busy),
    .frame_pointer(frame_pointer));
`default_nettype wire
